// *** core/ods_pkg.sv ***
// Operation
// - Selected only while select low; output tri-stated otherwise
// - Select fall loads comparator results into shifter
// - Select rise copies shifter into output latch
// - Output changes on clock rise, input sampled on fall
// - Channel seven first, channel zero last
// - Latch zero turns channel on, one off
// - First rising edge shows channel seven diagnostic
// - Unlimited bits pass through; last eight latched
// - Select rise starts blanking; faults ignored meanwhile
// - After blanking, faulted on channels are latched off
// - Fault clears only its own channel bit
// - Shift clock ignored while deselected
// - Host keeps shift clock low at select edges
// - Reset sets latch to all ones, all channels off
// - Open off channel reads back as zero
// - Host checks faults by resending same byte
// - Host reads one-when-on short, zero-when-off open
// - Reset acts synchronously on shifter and latch
package ods_pkg;
  localparam int          ODS_CHANNELS    = 8;
  localparam int          ODS_CLK_PERIOD_PS = 5000;
  // fault_blank_delay in microseconds
  localparam int          ODS_BLANK_US    = 160;
  localparam int          ODS_BLANK_CYC   = (ODS_BLANK_US * 1000000) / ODS_CLK_PERIOD_PS;
  localparam int          ODS_BLANK_W     = 16;
  // Host shift clock half period is this plus one, in core cycles (at most 2 MHz link)
  localparam int          ODS_HALF_CYC    = 60;
  localparam int          ODS_HALF_W      = 8;
  localparam logic [7:0]  ODS_ALL_OFF     = 8'hff;
  localparam logic [7:0]  ODS_ZERO8       = 8'h00;
  localparam logic [2:0]  ODS_BIT_LAST    = 3'h7;
  localparam logic [1:0]  ODS_SYNC_INIT   = 2'h0;
  localparam logic [1:0]  ODS_SYNC_HI     = 2'h3;
endpackage

// *** core/ods_link_if.sv ***
`timescale 1ns/1ps
interface ods_link_if;
  logic select_n;
  logic shift_clk;
  logic ser_in;
  logic ser_out;
  logic ser_out_oe;
  logic ser_wire;
  assign ser_wire = ser_out_oe ? ser_out : 1'b0;
  modport device (input select_n, input shift_clk, input ser_in,
                  output ser_out, output ser_out_oe);
  modport host (output select_n, output shift_clk, output ser_in, input ser_wire);
endinterface

// *** core/ods_buf2.sv ***
`timescale 1ns/1ps
module ods_buf2
  import ods_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Fill side
  input  wire logic       in_valid_in,
  output logic            in_ready_out,
  input  wire logic [7:0] in_data_in,
  // Drain side
  output logic            out_valid_out,
  input  wire logic       out_ready_in,
  output logic [7:0]      out_data_out
);
  logic [7:0] mem_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign in_ready_out  = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_reg[rd_ptr_reg];

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= 2'(count_reg + 2'(push) - 2'(pop));
    end
  end
endmodule

// *** core/ods_device.sv ***
`timescale 1ns/1ps
module ods_device
  import ods_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Serial link
  ods_link_if.device      link,
  // Channel side
  input  wire logic [7:0] comp_high_in,
  output logic [7:0]      latch_out,
  output logic [7:0]      chan_on_out,
  output logic            blanking_out
);
  logic [1:0]             sel_sync_reg;
  logic [1:0]             clk_sync_reg;
  logic [1:0]             si_sync_reg;
  logic [7:0]             comp_s1_reg;
  logic [7:0]             comp_s2_reg;
  logic                   sel_d_reg;
  logic                   clk_d_reg;
  logic [7:0]             shift_reg;
  logic [7:0]             latch_reg;
  logic                   so_reg;
  logic [ODS_BLANK_W-1:0] blank_cnt_reg;
  logic                   sel_n;
  logic                   sel_fall;
  logic                   sel_rise;
  logic                   clk_rise;
  logic                   clk_fall;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Reset is honoured synchronously here; the output latch still clears
  // to all ones within one cycle of reset, regardless of the link state.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      sel_sync_reg <= ODS_SYNC_HI;
      clk_sync_reg <= ODS_SYNC_INIT;
      si_sync_reg  <= ODS_SYNC_INIT;
      comp_s1_reg  <= ODS_ZERO8;
      comp_s2_reg  <= ODS_ZERO8;
      sel_d_reg    <= 1'b1;
      clk_d_reg    <= 1'b0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], link.select_n};
      clk_sync_reg <= {clk_sync_reg[0], link.shift_clk};
      si_sync_reg  <= {si_sync_reg[0], link.ser_in};
      comp_s1_reg  <= comp_high_in;
      comp_s2_reg  <= comp_s1_reg;
      sel_d_reg    <= sel_sync_reg[1];
      clk_d_reg    <= clk_sync_reg[1];
    end
  end

  assign sel_n    = sel_sync_reg[1];
  assign sel_fall = sel_d_reg && !sel_n;
  assign sel_rise = !sel_d_reg && sel_n;
  assign clk_rise = !sel_n && !clk_d_reg && clk_sync_reg[1];
  assign clk_fall = !sel_n && clk_d_reg && !clk_sync_reg[1];

  // ----------------------------------------------------------------
  // Shift register and serial output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      shift_reg <= ODS_ZERO8;
      so_reg    <= 1'b0;
    end else if (sel_fall) begin
      shift_reg <= comp_s2_reg;
    end else if (clk_rise) begin
      so_reg <= shift_reg[ODS_BIT_LAST];
    end else if (clk_fall) begin
      shift_reg <= {shift_reg[6:0], si_sync_reg[1]};
    end
  end

  assign link.ser_out    = so_reg;
  assign link.ser_out_oe = !sel_n;

  // ----------------------------------------------------------------
  // Output latch, blanking and fault clearing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      blank_cnt_reg <= '0;
    end else if (sel_rise) begin
      blank_cnt_reg <= ODS_BLANK_W'(ODS_BLANK_CYC);
    end else if (blank_cnt_reg != '0) begin
      blank_cnt_reg <= blank_cnt_reg - 1'b1;
    end
  end

  assign blanking_out = (blank_cnt_reg != '0);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      latch_reg <= ODS_ALL_OFF;
    end else if (sel_rise) begin
      latch_reg <= shift_reg;
    end else if (!blanking_out) begin
      latch_reg <= latch_reg | (~latch_reg & comp_s2_reg);
    end
  end

  assign latch_out   = latch_reg;
  assign chan_on_out = ~latch_reg;
endmodule

// *** core/ods_host.sv ***
`timescale 1ns/1ps
module ods_host
  import ods_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Command stream
  input  wire logic       cmd_valid_in,
  output logic            cmd_ready_out,
  input  wire logic [7:0] cmd_data_in,
  // Diagnostic stream
  output logic            diag_valid_out,
  input  wire logic       diag_ready_in,
  output logic [7:0]      diag_data_out,
  // Serial link
  ods_link_if.host        link
);
  typedef enum logic [3:0] {
    ODS_IDLE = 4'h1, ODS_LEAD = 4'h2, ODS_SHIFT = 4'h4, ODS_LAG = 4'h8
  } ods_state_t;

  ods_state_t            state_reg;
  logic [ODS_HALF_W-1:0] tick_reg;
  logic [2:0]            bit_reg;
  logic [7:0]            tx_reg;
  logic [7:0]            rx_reg;
  logic [1:0]            so_sync_reg;
  logic                  sel_n_reg;
  logic                  sclk_reg;
  logic                  push;
  logic                  tick_done;
  logic                  buf_room;

  assign tick_done     = (tick_reg == '0);
  // Ready only when the result of the transfer is sure of a buffer slot
  assign cmd_ready_out = (state_reg == ODS_IDLE) && buf_room;
  assign link.select_n = sel_n_reg;
  assign link.shift_clk = sclk_reg;
  assign link.ser_in   = tx_reg[ODS_BIT_LAST];

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      so_sync_reg <= ODS_SYNC_INIT;
    end else begin
      so_sync_reg <= {so_sync_reg[0], link.ser_wire};
    end
  end

  // Diagnostic words queue here so a slow reader stalls new transfers
  ods_buf2 u_buf (
    .core_clk_in   (core_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (push),
    .in_ready_out  (buf_room),
    .in_data_in    (rx_reg),
    .out_valid_out (diag_valid_out),
    .out_ready_in  (diag_ready_in),
    .out_data_out  (diag_data_out)
  );

  assign push     = (state_reg == ODS_LAG) && tick_done;

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_reg <= ODS_IDLE;
      tick_reg  <= '0;
      bit_reg   <= '0;
      tx_reg    <= ODS_ALL_OFF;
      rx_reg    <= ODS_ZERO8;
      sel_n_reg <= 1'b1;
      sclk_reg  <= 1'b0;
    end else begin
      tick_reg <= tick_done ? ODS_HALF_W'(ODS_HALF_CYC) : tick_reg - 1'b1;
      unique case (state_reg)
        ODS_IDLE: begin
          tick_reg <= ODS_HALF_W'(ODS_HALF_CYC);
          // Only one transfer is in flight, so a free slot now is free at push
          if (cmd_valid_in && buf_room) begin
            tx_reg    <= cmd_data_in;
            sel_n_reg <= 1'b0;
            bit_reg   <= '0;
            state_reg <= ODS_LEAD;
          end
        end
        ODS_LEAD: begin
          if (tick_done) begin
            sclk_reg  <= 1'b1;
            state_reg <= ODS_SHIFT;
          end
        end
        ODS_SHIFT: begin
          if (tick_done && sclk_reg) begin
            sclk_reg <= 1'b0;
            rx_reg   <= {rx_reg[6:0], so_sync_reg[1]};
          end else if (tick_done) begin
            tx_reg  <= {tx_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == ODS_BIT_LAST) begin
              state_reg <= ODS_LAG;
            end else begin
              sclk_reg <= 1'b1;
            end
          end
        end
        ODS_LAG: begin
          if (tick_done) begin
            sel_n_reg <= 1'b1;
            state_reg <= ODS_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// *** tb/ods_link_checker.sv ***
`timescale 1ns/1ps
module ods_link_checker (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Link wires
  input wire logic select_n,
  input wire logic shift_clk,
  input wire logic ser_in,
  input wire logic ser_out,
  input wire logic ser_out_oe,
  input wire logic ser_wire
);
  logic [3:0] rise_cnt_reg;
  logic [3:0] rise_age_reg;
  logic [10:0] low_cnt_reg;
  localparam logic [10:0] FRAME_MIN = 11'h3e8;
  localparam logic [10:0] FRAME_MAX = 11'h4b0;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // --------------------------------------------------
  // Frame bookkeeping
  // --------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || $fell(select_n)) rise_cnt_reg <= 4'h0;
    else if ($rose(shift_clk)) rise_cnt_reg <= rise_cnt_reg + 4'h1;
  end
  // Saturates so a long idle gap never wraps back into the legal window
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || $rose(shift_clk)) rise_age_reg <= 4'h0;
    else if (rise_age_reg != 4'hf) rise_age_reg <= rise_age_reg + 4'h1;
  end
  // Frame length in cycles; a delay range this long would be too costly to unroll
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || select_n) low_cnt_reg <= 11'h0;
    else if (low_cnt_reg != 11'h7ff) low_cnt_reg <= low_cnt_reg + 11'h1;
  end
  sequence s_clk_low;
    !shift_clk[*8];
  endsequence
  sequence s_clk_rise_or_low;
    $rose(shift_clk) || !shift_clk;
  endsequence
  property p_oe_idle;  select_n[*4] |-> !ser_out_oe; endproperty
  property p_oe_sel;   !select_n[*4] |-> ser_out_oe; endproperty
  property p_lead;     $fell(select_n) |-> s_clk_low; endproperty
  property p_lag;      $rose(select_n) |-> !shift_clk && !$past(shift_clk, 8); endproperty
  property p_gate;     select_n |-> !shift_clk; endproperty
  property p_count;    $rose(select_n) |-> rise_cnt_reg == 4'h8; endproperty
  property p_so_time;  (ser_out_oe && $changed(ser_out)) |-> rise_age_reg <= 4'h7; endproperty
  property p_frame;
    $rose(select_n) |-> (low_cnt_reg >= FRAME_MIN) && (low_cnt_reg <= FRAME_MAX);
  endproperty
  property p_frame_open; !select_n |-> low_cnt_reg <= FRAME_MAX; endproperty
  property p_si_hold;  $changed(ser_in) |-> s_clk_rise_or_low; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("serial out driven while idle");
  a_oe_sel: assert property (p_oe_sel) else $error("serial out not driven");
  a_lead: assert property (p_lead) else $error("shift clock high at select fall");
  a_lag: assert property (p_lag) else $error("shift clock high at select rise");
  a_gate: assert property (p_gate) else $error("shift clock while deselected");
  a_count: assert property (p_count) else $error("frame without eight clocks");
  a_so_time: assert property (p_so_time) else $error("serial out moved off clock rise");
  a_frame: assert property (p_frame) else $error("frame length out of range");
  a_frame_open: assert property (p_frame_open) else $error("frame never ends");
  a_si_hold: assert property (p_si_hold) else $error("serial in moved while clock high");
endmodule

// *** tb/octal_driver_serial_control_tb.sv ***
`timescale 1ns/1ps
module octal_driver_serial_control_tb;
  import ods_pkg::*;
  logic       core_clk_in;
  logic       reset_n_in;
  logic       cmd_valid_in;
  logic       cmd_ready_out;
  logic [7:0] cmd_data_in;
  logic       diag_valid_out;
  logic       diag_ready_in;
  logic [7:0] diag_data_out;
  logic [7:0] comp_high_in;
  logic [7:0] latch_out;
  logic [7:0] chan_on_out;
  logic       blanking_out;
  int         n_errors = 0;
  int         tests_run = 0;
  int         cyc = 0;
  ods_link_if link ();
  ods_host u_ods_host (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_data_in(cmd_data_in),
    .diag_valid_out(diag_valid_out), .diag_ready_in(diag_ready_in),
    .diag_data_out(diag_data_out), .link(link));
  ods_device u_ods_device (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .link(link),
    .comp_high_in(comp_high_in), .latch_out(latch_out), .chan_on_out(chan_on_out),
    .blanking_out(blanking_out));
  ods_link_checker u_ods_link_checker (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .select_n(link.select_n), .shift_clk(link.shift_clk), .ser_in(link.ser_in),
    .ser_out(link.ser_out), .ser_out_oe(link.ser_out_oe), .ser_wire(link.ser_wire));
  // --------------------------------------------------
  // Clock, watchdog and helpers
  // --------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic conclude();
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Blanking alone is 32000 cycles; everything else fits in a few thousand
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic take();
    do @(posedge core_clk_in); while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 1'b0;
  endtask
  // Comparators settle before the command so the select fall sees them synced
  task automatic push(input logic [7:0] cmd, input logic [7:0] comp);
    comp_high_in <= comp;
    repeat (4) @(posedge core_clk_in);
    cmd_data_in  <= cmd;
    cmd_valid_in <= 1'b1;
    take();
  endtask
  task automatic wait_frame();
    wait (link.select_n === 1'b0);
    wait (link.select_n === 1'b1);
    repeat (8) @(posedge core_clk_in);
  endtask
  task automatic pop(input logic [7:0] exp);
    @(posedge core_clk_in);
    while (diag_valid_out !== 1'b1) @(posedge core_clk_in);
    cmp8(diag_data_out, exp);
    diag_ready_in <= 1'b1;
    @(posedge core_clk_in);
    diag_ready_in <= 1'b0;
  endtask
  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic sc_reset();
    cmp8(latch_out, ODS_ALL_OFF);
    cmp8(chan_on_out, ODS_ZERO8);
    cmp1(link.ser_out_oe, 1'b0);
  endtask
  task automatic sc_buffer();
    push(8'h3c, 8'ha5);
    wait_frame();
    cmp8(latch_out, 8'h3c);
    cmp8(chan_on_out, 8'hc3);
    cmp1(blanking_out, 1'b1);
    push(8'hc3, 8'h5a);
    wait_frame();
    comp_high_in <= 8'h96;
    cmd_data_in  <= 8'h0f;
    cmd_valid_in <= 1'b1;
    repeat (1200) @(posedge core_clk_in);
    cmp1(link.select_n, 1'b1);
    cmp8(latch_out, 8'hc3);
    pop(8'ha5);
    take();
    pop(8'h5a);
    wait_frame();
    pop(8'h96);
    @(posedge core_clk_in);
    cmp1(diag_valid_out, 1'b0);
    cmp8(latch_out, 8'h0f);
  endtask
  task automatic sc_fault();
    comp_high_in <= 8'h91;
    repeat (100) @(posedge core_clk_in);
    cmp8(latch_out, 8'h0f);
    while (blanking_out !== 1'b0) @(posedge core_clk_in);
    repeat (8) @(posedge core_clk_in);
    cmp8(latch_out, 8'h9f);
    comp_high_in <= 8'hb1;
    repeat (8) @(posedge core_clk_in);
    cmp8(latch_out, 8'hbf);
    cmp8(chan_on_out, 8'h40);
    push(8'h0f, 8'hb1);
    pop(8'hb1);
    repeat (4) @(posedge core_clk_in);
    cmp8(latch_out, 8'h0f);
  endtask
  task automatic sc_reset_mid();
    reset_n_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    cmp8(latch_out, ODS_ALL_OFF);
    cmp1(link.select_n, 1'b1);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
  endtask
  initial begin
    reset_n_in    = 1'b0;
    cmd_valid_in  = 1'b0;
    cmd_data_in   = 8'h00;
    diag_ready_in = 1'b0;
    comp_high_in  = 8'h00;
    repeat (16) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    sc_reset();
    sc_buffer();
    sc_fault();
    sc_reset_mid();
    conclude();
  end
endmodule
